// ===== hw/uhi_pkg.sv
// shared constants of the serial channel: register map, field positions, resets
// assumes a single 25 MHz clock and the 3-bit host register address
package uhi_pkg;
  localparam int unsigned CLK_HZ     = 25_000_000;
  // register addresses
  localparam logic [2:0] ADDR_HOLD   = 3'h0;
  localparam logic [2:0] ADDR_IEN    = 3'h1;
  localparam logic [2:0] ADDR_SRC    = 3'h2;
  localparam logic [2:0] ADDR_LSR    = 3'h5;
  // interrupt enable fields
  localparam int unsigned IEN_RX     = 0;
  localparam int unsigned IEN_TX     = 1;
  localparam int unsigned IEN_LS     = 2;
  localparam int unsigned IEN_MS     = 3;
  localparam logic [3:0] IEN_RESET   = 4'h0;
  // fifo control fields
  localparam int unsigned FCR_EN     = 0;
  localparam int unsigned FCR_RXCLR  = 1;
  localparam int unsigned FCR_TXCLR  = 2;
  localparam int unsigned FCR_TRIG   = 6;
  localparam logic [1:0] TRIG_RESET  = 2'h0;
  // receive trigger levels for codes 00..11
  localparam logic [4:0] TRIG_L0     = 5'h01;
  localparam logic [4:0] TRIG_L1     = 5'h04;
  localparam logic [4:0] TRIG_L2     = 5'h08;
  localparam logic [4:0] TRIG_L3     = 5'h0e;
  // interrupt source codes, bits 3:0
  localparam logic [3:0] SRC_NONE    = 4'h1;
  localparam logic [3:0] SRC_LS      = 4'h6;
  localparam logic [3:0] SRC_RX      = 4'h4;
  localparam logic [3:0] SRC_TX      = 4'h2;
  localparam logic [3:0] SRC_MS      = 4'h0;
  // serial timing in 16x ticks, clocks per tick, fifo depth
  localparam int unsigned OVERSAMPLE = 16;
  localparam int unsigned START_HALF = 15;
  localparam int unsigned START_TICK = (START_HALF + 1) / 2;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned BAUD_DIV   = 13;
endpackage

// ===== hw/uhi_fifo_if.sv
// fifo port bundle between the channel core and its two fifos
// assumes the owner drives push/pop only as single-cycle strobes
`timescale 1ns/1ps
`default_nettype none
interface uhi_fifo_if #(parameter int W = 8, parameter int AW = 4);
  logic          push;
  logic          pop;
  logic          clr;
  logic [W-1:0]  wdata;
  logic [W-1:0]  rdata;
  logic [AW:0]   count;
  modport ctrl  (output push, pop, clr, wdata, input rdata, count);
  modport store (input push, pop, clr, wdata, output rdata, count);
endinterface
`default_nettype wire

// ===== hw/uhi_fifo.sv
// synchronous fifo with head word always visible on rdata
// assumes DEPTH is a power of two; push when full and pop when empty are ignored
`timescale 1ns/1ps
`default_nettype none
module uhi_fifo #(
  parameter int DEPTH = 16,
  parameter int W     = 8,
  parameter int AW    = 4
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  uhi_fifo_if.store f
);
  localparam logic [AW:0] FULL_C = (AW+1)'(DEPTH);
  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0]   cnt_q;
  wire           do_push = f.push && (cnt_q != FULL_C);
  wire           do_pop  = f.pop && (cnt_q != '0);

  assign f.rdata = mem[rp_q];
  assign f.count = cnt_q;

  always_ff @(posedge clk)
  begin
    if (ce && do_push)
      mem[wp_q] <= f.wdata;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end
    else if (ce)
    begin
      if (f.clr)
      begin
        wp_q  <= '0;
        rp_q  <= '0;
        cnt_q <= '0;
      end
      else
      begin
        wp_q  <= wp_q + AW'(do_push);
        rp_q  <= rp_q + AW'(do_pop);
        cnt_q <= cnt_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
      end
    end
  end
endmodule // uhi_fifo
`default_nettype wire

// ===== hw/uhi_rx.sv
// receive shifter: start validation, 8 data bits, one stop bit, on 16x ticks
// assumes rxd is already synchronous to clk and idles high
`timescale 1ns/1ps
`default_nettype none
module uhi_rx
  import uhi_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic       tick,
  input  wire logic       rxd,
  output logic            valid,
  output logic [7:0]      data,
  output logic            frame_err,
  output logic            brk
);
  typedef enum logic [1:0] {HUNT, START, DATA, STOP} uhi_rx_st_t;
  localparam logic [3:0] SUB_LAST   = 4'(OVERSAMPLE - 1);
  localparam logic [3:0] START_LAST = 4'(START_TICK - 1);
  uhi_rx_st_t st_q;
  logic       prev_q;
  logic [3:0] sub_q;
  logic [2:0] bit_q;
  wire        fall    = prev_q && !rxd;
  wire        mid_bit = tick && (sub_q == SUB_LAST);
  wire        mid_st  = tick && (sub_q == START_LAST);

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_q <= HUNT; prev_q <= 1'b1; sub_q <= '0; bit_q <= '0;
      valid <= 1'b0; data <= '0; frame_err <= 1'b0; brk <= 1'b0;
    end
    else if (ce)
    begin
      prev_q <= rxd;
      valid  <= 1'b0;
      if (tick)
        sub_q <= (st_q == HUNT || mid_st && st_q == START || mid_bit) ? 4'h0 : sub_q + 4'h1;
      case (st_q)
        HUNT:
          if (fall)
          begin
            st_q  <= START;
            sub_q <= '0;
          end
        START:
          if (mid_st)
            st_q <= rxd ? HUNT : DATA;
        DATA:
          if (mid_bit)
          begin
            data  <= {rxd, data[7:1]};
            bit_q <= bit_q + 3'h1;
            if (bit_q == 3'h7)
              st_q <= STOP;
          end
        STOP:
          if (mid_bit)
          begin
            valid     <= 1'b1;
            frame_err <= !rxd;
            brk       <= !rxd && (data == 8'h00);
            st_q      <= HUNT;
          end
        default: st_q <= HUNT;
      endcase
    end
  end

  property p_false_start;
    @(posedge clk) disable iff (rst)
    (ce && st_q == START && mid_st && rxd) |=> (st_q == HUNT && !valid);
  endproperty
  a_false_start: assert property (p_false_start) else $error("false start not discarded");

  property p_start_wait;
    @(posedge clk) disable iff (rst)
    (ce && st_q == HUNT && fall) |=> (st_q == START && sub_q == 4'h0);
  endproperty
  a_start_wait: assert property (p_start_wait) else $error("start counter not begun");
endmodule // uhi_rx
`default_nettype wire

// ===== hw/uhi_core.sv
// one serial channel: holding registers, fifos, line status, interrupt enable
// assumes a host bus synchronous to I_CLK with active-low select and strobes
`timescale 1ns/1ps
`default_nettype none
module uhi_core
  import uhi_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH,
  parameter int DIV   = BAUD_DIV
) (
  // clock, reset, enable
  input  wire logic       I_CLK,
  input  wire logic       I_RESET,
  input  wire logic       I_CE,
  // host register bus
  input  wire logic       I_CS_N,
  input  wire logic       I_RD_N,
  input  wire logic       I_WR_N,
  input  wire logic [2:0] I_ADDR,
  input  wire logic [7:0] I_DATA,
  output logic      [7:0] O_DATA,
  output logic            O_DATA_OE,
  // serial line and modem
  input  wire logic       I_RXD,
  output logic            O_TXD,
  input  wire logic       I_MODEM_EVT,
  output logic            O_INT
);
  localparam int          AW     = $clog2(DEPTH);
  localparam logic [AW:0] FULL_C = (AW+1)'(DEPTH);
  localparam int          DW     = $clog2(DIV + 1);

  ////////////////////////////////////////////////////////////////////////////
  // host access decode, one access per strobe
  logic        rd_prev_q;
  logic        wr_prev_q;
  wire         rd_now   = !I_CS_N && !I_RD_N;
  wire         wr_now   = !I_CS_N && !I_WR_N;
  wire         rd_start = rd_now && !rd_prev_q;
  wire         wr_start = wr_now && !wr_prev_q;
  wire         rd_hold  = rd_start && (I_ADDR == ADDR_HOLD);
  wire         rd_src   = rd_start && (I_ADDR == ADDR_SRC);
  wire         rd_lsr   = rd_start && (I_ADDR == ADDR_LSR);
  wire         wr_hold  = wr_start && (I_ADDR == ADDR_HOLD);
  wire         wr_ien   = wr_start && (I_ADDR == ADDR_IEN);
  wire         wr_fcr   = wr_start && (I_ADDR == ADDR_SRC) && I_DATA[FCR_EN];
  wire         wr_fdis  = wr_start && (I_ADDR == ADDR_SRC) && !I_DATA[FCR_EN];

  ////////////////////////////////////////////////////////////////////////////
  // control registers
  logic [3:0]  ien_q;
  logic        fifo_en_q;
  logic [1:0]  trig_q;
  logic [4:0]  trig_lvl;

  always_ff @(posedge I_CLK)
  begin
    if (I_RESET)
    begin
      ien_q     <= IEN_RESET;
      fifo_en_q <= 1'b0;
      trig_q    <= TRIG_RESET;
      rd_prev_q <= 1'b0;
      wr_prev_q <= 1'b0;
    end
    else if (I_CE)
    begin
      rd_prev_q <= rd_now;
      wr_prev_q <= wr_now;
      if (wr_ien)
        ien_q <= I_DATA[3:0];
      if (wr_fcr)
      begin
        fifo_en_q <= 1'b1;
        trig_q    <= I_DATA[FCR_TRIG+1:FCR_TRIG];
      end
      else if (wr_fdis)
        fifo_en_q <= 1'b0;
    end
  end

  // trigger code to fill level
  always_comb
  begin
    case (trig_q)
      2'h0:    trig_lvl = TRIG_L0;
      2'h1:    trig_lvl = TRIG_L1;
      2'h2:    trig_lvl = TRIG_L2;
      default: trig_lvl = TRIG_L3;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // 16x tick
  logic [DW-1:0] div_q;
  wire           tick = (div_q == DW'(DIV - 1));

  always_ff @(posedge I_CLK)
  begin
    if (I_RESET)
      div_q <= '0;
    else if (I_CE)
      div_q <= tick ? '0 : div_q + DW'(1);
  end

  ////////////////////////////////////////////////////////////////////////////
  // fifos; with fifos off each holds a single byte
  uhi_fifo_if #(.W(8), .AW(AW))  txf ();
  uhi_fifo_if #(.W(10), .AW(AW)) rxf ();
  uhi_fifo #(.DEPTH(DEPTH), .W(8), .AW(AW)) u_txf (
    .clk (I_CLK),
    .rst (I_RESET),
    .ce  (I_CE),
    .f   (txf)
  );
  uhi_fifo #(.DEPTH(DEPTH), .W(10), .AW(AW)) u_rxf (
    .clk (I_CLK),
    .rst (I_RESET),
    .ce  (I_CE),
    .f   (rxf)
  );
  wire tx_full  = fifo_en_q ? (txf.count == FULL_C) : (txf.count != '0);
  wire tx_empty = (txf.count == '0);
  wire rx_full  = fifo_en_q ? (rxf.count == FULL_C) : (rxf.count != '0);
  wire rx_empty = (rxf.count == '0);

  ////////////////////////////////////////////////////////////////////////////
  // transmitter: 8N1 from the tx fifo
  logic       tx_busy_q;
  logic [9:0] tx_sh_q;
  logic [3:0] tx_sub_q;
  logic [3:0] tx_bit_q;
  wire        tx_load = !tx_busy_q && !tx_empty;

  assign txf.push  = wr_hold && !tx_full;
  assign txf.wdata = I_DATA;
  assign txf.pop   = tx_load;
  assign txf.clr   = wr_fcr && I_DATA[FCR_TXCLR];

  always_ff @(posedge I_CLK)
  begin
    if (I_RESET)
    begin
      tx_busy_q <= 1'b0; tx_sh_q <= '1; tx_sub_q <= '0; tx_bit_q <= '0;
      O_TXD     <= 1'b1;
    end
    else if (I_CE)
    begin
      O_TXD <= tx_busy_q ? tx_sh_q[0] : 1'b1;
      if (tx_load)
      begin
        tx_busy_q <= 1'b1;
        tx_sh_q   <= {1'b1, txf.rdata, 1'b0};
        tx_sub_q  <= '0;
        tx_bit_q  <= '0;
      end
      else if (tx_busy_q && tick)
      begin
        tx_sub_q <= tx_sub_q + 4'h1;
        if (tx_sub_q == 4'(OVERSAMPLE - 1))
        begin
          tx_sh_q  <= {1'b1, tx_sh_q[9:1]};
          tx_bit_q <= tx_bit_q + 4'h1;
          if (tx_bit_q == 4'h9)
            tx_busy_q <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receiver and error tracking
  logic       rx_valid;
  logic [7:0] rx_data;
  logic       rx_fe;
  logic       rx_brk;
  logic       oe_q;
  logic       fe_q;
  logic       bi_q;
  logic [AW:0] err_cnt_q;

  uhi_rx u_rx (
    .clk       (I_CLK),
    .rst       (I_RESET),
    .ce        (I_CE),
    .tick      (tick),
    .rxd       (I_RXD),
    .valid     (rx_valid),
    .data      (rx_data),
    .frame_err (rx_fe),
    .brk       (rx_brk)
  );

  wire rx_push = rx_valid && !rx_full;
  wire rx_pop  = rd_hold && !rx_empty;
  wire in_err  = rx_fe || rx_brk;
  wire top_err = |rxf.rdata[9:8];

  assign rxf.push  = rx_push;
  assign rxf.wdata = {rx_brk, rx_fe, rx_data};
  assign rxf.pop   = rx_pop;
  assign rxf.clr   = wr_fcr && I_DATA[FCR_RXCLR];

  // sticky errors: a new event in the clearing read wins
  always_ff @(posedge I_CLK)
  begin
    if (I_RESET)
    begin
      oe_q <= 1'b0; fe_q <= 1'b0; bi_q <= 1'b0; err_cnt_q <= '0;
    end
    else if (I_CE)
    begin
      oe_q <= (rx_valid && rx_full) || (oe_q && !rd_lsr);
      fe_q <= (rx_push && rx_fe) || (fe_q && !rd_lsr);
      bi_q <= (rx_push && rx_brk) || (bi_q && !rd_lsr);
      if (rxf.clr)
        err_cnt_q <= '0;
      else
        err_cnt_q <= err_cnt_q + (AW+1)'(rx_push && in_err) - (AW+1)'(rx_pop && top_err);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // line status, interrupt sources, read data
  logic        tx_empty_prev_q;
  logic        thre_pend_q;
  logic [3:0]  src_code;
  wire         temt    = tx_empty && !tx_busy_q;
  wire         thre    = !tx_full;
  // parity is not generated, so bit 2 stays clear
  wire  [7:0]  lsr_val = {err_cnt_q != '0, temt, thre, bi_q, fe_q, 1'b0, oe_q, !rx_empty};
  wire         rx_lvl  = fifo_en_q ? (rxf.count >= trig_lvl) : !rx_empty;
  wire         ls_irq  = ien_q[IEN_LS] && (oe_q || fe_q || bi_q);
  wire         rx_irq  = ien_q[IEN_RX] && rx_lvl;
  wire         tx_irq  = ien_q[IEN_TX] && thre_pend_q;
  wire         ms_irq  = ien_q[IEN_MS] && I_MODEM_EVT;
  wire         any_irq = ls_irq || rx_irq || tx_irq || ms_irq;
  wire  [7:0]  src_val = {fifo_en_q, fifo_en_q, 2'b00, src_code};
  wire         thre_set = tx_empty && !tx_empty_prev_q;
  wire         thre_clr = wr_hold || (rd_src && src_code == SRC_TX);
  logic [7:0]  rd_mux;

  always_comb
  begin
    if (ls_irq)
      src_code = SRC_LS;
    else if (rx_irq)
      src_code = SRC_RX;
    else if (tx_irq)
      src_code = SRC_TX;
    else if (ms_irq)
      src_code = SRC_MS;
    else
      src_code = SRC_NONE;
  end

  always_comb
  begin
    case (I_ADDR)
      ADDR_HOLD: rd_mux = rxf.rdata[7:0];
      ADDR_IEN:  rd_mux = {4'h0, ien_q};
      ADDR_SRC:  rd_mux = src_val;
      ADDR_LSR:  rd_mux = lsr_val;
      default:   rd_mux = 8'h00;
    endcase
  end

  // empty event sets the pending flag even if a clear lands together
  always_ff @(posedge I_CLK)
  begin
    if (I_RESET)
    begin
      tx_empty_prev_q <= 1'b1; thre_pend_q <= 1'b0;
      O_DATA <= 8'h00; O_DATA_OE <= 1'b0; O_INT <= 1'b0;
    end
    else if (I_CE)
    begin
      tx_empty_prev_q <= tx_empty;
      thre_pend_q     <= thre_set || (thre_pend_q && !thre_clr);
      O_INT           <= any_irq;
      O_DATA_OE       <= rd_now;
      if (rd_start)
        O_DATA <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RESET);

  property p_ien_reset;
    $fell(I_RESET) |-> (ien_q == 4'h0 && !O_INT);
  endproperty
  a_ien_reset: assert property (p_ien_reset) else $error("enables not cleared by reset");

  property p_tx_capture;
    (I_CE && wr_hold && !tx_full && !txf.clr) |=> (txf.count == $past(txf.count) + (AW+1)'(1) - (AW+1)'($past(tx_load)));
  endproperty
  a_tx_capture: assert property (p_tx_capture) else $error("host byte not captured");

  property p_full_flag;
    (fifo_en_q && txf.count == FULL_C) |-> !lsr_val[5] ##0 (!wr_hold || !txf.push);
  endproperty
  a_full_flag: assert property (p_full_flag) else $error("empty flag set on full fifo");

  property p_rx_pop;
    (I_CE && rd_hold && !rx_empty && !rxf.clr) |=> (rxf.count == $past(rxf.count) - (AW+1)'(1) + (AW+1)'($past(rx_push)));
  endproperty
  a_rx_pop: assert property (p_rx_pop) else $error("read did not remove byte");

  property p_dr;
    (I_CE && rx_push) |=> lsr_val[0];
  endproperty
  a_dr: assert property (p_dr) else $error("data ready not set");

  property p_rx_irq;
    (I_CE && fifo_en_q && ien_q[IEN_RX] && rxf.count >= trig_lvl) |=> O_INT;
  endproperty
  a_rx_irq: assert property (p_rx_irq) else $error("trigger interrupt missing");

  property p_masked;
    (I_CE && ien_q == 4'h0) |=> !O_INT;
  endproperty
  a_masked: assert property (p_masked) else $error("masked source drove interrupt");

  property p_temt;
    lsr_val[6] |-> (txf.count == '0 && !tx_busy_q);
  endproperty
  a_temt: assert property (p_temt) else $error("shifter empty flag early");

  c_rx_push: cover property (I_CE && rx_push);
  c_rx_src:  cover property (rd_src && src_code == SRC_RX);
  c_overrun: cover property (I_CE && rx_valid && rx_full);
endmodule // uhi_core
`default_nettype wire

// ===== tb/uhi_line_peer.sv
// serial line partner: sends 8N1 frames into rxd, collects frames seen on txd
// assumes a bit time of BIT clocks and a line that idles high
`timescale 1ns/1ps
`default_nettype none
module uhi_line_peer #(
  parameter int BIT = 16
) (
  input  wire logic clk,
  input  wire logic txd,
  output logic      rxd
);
  logic [7:0] got[$];
  logic [7:0] sh;
  initial rxd = 1'b1;
  ////////////////////////////////////////
  // stop_ok low sends a low stop bit, so a zero byte also forms a break
  task automatic send(input logic [7:0] b, input logic stop_ok);
    logic [9:0] f;
    f = {stop_ok, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      rxd <= f[i];
      repeat (BIT) @(posedge clk);
    end
    rxd <= 1'b1;
    repeat (BIT) @(posedge clk);
  endtask
  // low for a quarter bit only: gone before the mid-bit sample
  task automatic glitch();
    rxd <= 1'b0;
    repeat (BIT / 4) @(posedge clk);
    rxd <= 1'b1;
    repeat (2 * BIT) @(posedge clk);
  endtask
  // samples each bit in its middle, lsb first
  always
  begin
    @(negedge txd);
    repeat (BIT / 2) @(posedge clk);
    for (int i = 0; i < 8; i++)
    begin
      repeat (BIT) @(posedge clk);
      sh[i] = txd;
    end
    repeat (BIT) @(posedge clk);
    got.push_back(sh);
  end
endmodule // uhi_line_peer
`default_nettype wire

// ===== tb/tb_uart_holding_and_irq_enable.sv
// self-checking bench for one serial channel: registers, fifos, interrupts
// assumes DIV=1, so one bit time is 16 clocks of the 25 MHz clock
`timescale 1ns/1ps
`default_nettype none
module tb_uart_holding_and_irq_enable;
  import uhi_pkg::*;
  localparam int BIT = 16;
  logic       clk, rst, ce, cs_n, rd_n, wr_n, mevt, oe, txd, rxd, irq;
  logic [2:0] addr;
  logic [7:0] wdat, rdat;
  int         fail_count, checks;
  uhi_core #(.DEPTH(16), .DIV(1)) DUT (.I_CLK(clk), .I_RESET(rst), .I_CE(ce),
    .I_CS_N(cs_n), .I_RD_N(rd_n), .I_WR_N(wr_n), .I_ADDR(addr), .I_DATA(wdat),
    .O_DATA(rdat), .O_DATA_OE(oe), .I_RXD(rxd), .O_TXD(txd), .I_MODEM_EVT(mevt), .O_INT(irq));
  uhi_line_peer #(.BIT(BIT)) PEER (.clk(clk), .txd(txd), .rxd(rxd));
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  ////////////////////////////////////////
  task automatic close_out();
    if (fail_count == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input string n, input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // strobes high for one cycle after every access, as the bus needs
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    {cs_n, rd_n, wr_n} = 3'b010;
    addr = a;
    wdat = d;
    cyc(1);
    {cs_n, rd_n, wr_n} = 3'b111;
    cyc(1);
  endtask
  task automatic rdc(input string n, input logic [2:0] a, input logic [7:0] e);
    {cs_n, rd_n, wr_n} = 3'b001;
    addr = a;
    cyc(1);
    check(n, rdat, e);
    check("oe", {7'h0, oe}, 8'h01);
    {cs_n, rd_n, wr_n} = 3'b111;
    cyc(1);
    check("oe_off", {7'h0, oe}, 8'h00);
  endtask
  task automatic irqc(input logic e);
    check("int", {7'h0, irq}, {7'h0, e});
  endtask
  task automatic send(input logic [7:0] b, input logic ok);
    PEER.send(b, ok);
    cyc(4);
  endtask
  // bounded wait for frames out on the serial line
  task automatic wait_tx(input int n);
    int k = 0;
    while (PEER.got.size() < n && k < 20000)
    begin
      cyc(1);
      k++;
    end
    if (PEER.got.size() < n)
    begin
      fail_count++;
      close_out();
    end
  endtask
  ////////////////////////////////////////
  task automatic t_reset();
    rdc("lsr", ADDR_LSR, 8'h60);
    rdc("src", ADDR_SRC, 8'h01);
    rdc("ien", ADDR_IEN, 8'h00);
    irqc(1'b0);
  endtask
  task automatic t_modem();
    mevt = 1'b1;
    cyc(3);
    irqc(1'b0);
    wr(ADDR_IEN, 8'h08);
    cyc(2);
    irqc(1'b1);
    rdc("ien", ADDR_IEN, 8'h08);
    rdc("src", ADDR_SRC, 8'h00);
    wr(ADDR_IEN, 8'h00);
    cyc(2);
    irqc(1'b0);
    mevt = 1'b0;
  endtask
  task automatic t_tx();
    wr(ADDR_IEN, 8'h02);
    wr(ADDR_HOLD, 8'ha5);
    cyc(2);
    rdc("lsr", ADDR_LSR, 8'h20);
    irqc(1'b1);
    rdc("src", ADDR_SRC, 8'h02);
    cyc(2);
    irqc(1'b0);
    wait_tx(1);
    check("txd", PEER.got[0], 8'ha5);
    cyc(2 * BIT);
    rdc("lsr", ADDR_LSR, 8'h60);
    wr(ADDR_IEN, 8'h00);
  endtask
  // one byte lands in the shifter, sixteen fill the fifo, the last is dropped
  task automatic t_fifo_tx();
    wr(ADDR_SRC, 8'h01);
    for (int i = 0; i < 18; i++)
      wr(ADDR_HOLD, 8'h10 + i[7:0]);
    rdc("lsr", ADDR_LSR, 8'h00);
    wait_tx(18);
    for (int i = 0; i < 17; i++)
      check("txd", PEER.got[1 + i], 8'h10 + i[7:0]);
    cyc(12 * BIT);
    check("frames", 8'(PEER.got.size()), 8'd18);
    rdc("lsr", ADDR_LSR, 8'h60);
  endtask
  task automatic t_trig(input logic [1:0] code, input int lvl);
    wr(ADDR_SRC, {code, 6'h01});
    wr(ADDR_IEN, 8'h01);
    for (int i = 0; i < lvl - 1; i++)
      send({code, 6'h00} + i[7:0], 1'b1);
    irqc(1'b0);
    send({code, 6'h00} + lvl[7:0] - 8'h01, 1'b1);
    irqc(1'b1);
    rdc("src", ADDR_SRC, 8'hc4);
    for (int i = 0; i < lvl; i++)
    begin
      if (i == lvl - 1)
        rdc("lsr", ADDR_LSR, 8'h61);
      rdc("rx", ADDR_HOLD, {code, 6'h00} + i[7:0]);
      if (i == 0)
        irqc(1'b0);
    end
    cyc(2);
    irqc(1'b0);
    rdc("lsr", ADDR_LSR, 8'h60);
    wr(ADDR_IEN, 8'h00);
  endtask
  task automatic t_false();
    PEER.glitch();
    cyc(2);
    rdc("lsr", ADDR_LSR, 8'h60);
    send(8'h3c, 1'b1);
    irqc(1'b0);
    rdc("lsr", ADDR_LSR, 8'h61);
    rdc("rx", ADDR_HOLD, 8'h3c);
  endtask
  task automatic t_err();
    wr(ADDR_IEN, 8'h04);
    send(8'h00, 1'b0);
    irqc(1'b1);
    rdc("src", ADDR_SRC, 8'hc6);
    rdc("lsr", ADDR_LSR, 8'hf9);
    rdc("lsr", ADDR_LSR, 8'he1);
    rdc("rx", ADDR_HOLD, 8'h00);
    rdc("lsr", ADDR_LSR, 8'h60);
    irqc(1'b0);
    wr(ADDR_IEN, 8'h00);
  endtask
  // fifo clears, overrun with fifos off, clock-enable freeze, reset in mid-run
  task automatic t_misc();
    send(8'h11, 1'b1);
    send(8'h22, 1'b1);
    rdc("lsr", ADDR_LSR, 8'h61);
    wr(ADDR_SRC, 8'h03);
    rdc("lsr", ADDR_LSR, 8'h60);
    wr(ADDR_SRC, 8'h00);
    rdc("src", ADDR_SRC, 8'h01);
    send(8'h33, 1'b1);
    send(8'h44, 1'b1);
    rdc("lsr", ADDR_LSR, 8'h63);
    rdc("rx", ADDR_HOLD, 8'h33);
    rdc("lsr", ADDR_LSR, 8'h60);
    // first byte goes to the shifter, the two queued behind it are cleared
    wr(ADDR_SRC, 8'h01);
    wr(ADDR_HOLD, 8'h55);
    wr(ADDR_HOLD, 8'h66);
    wr(ADDR_HOLD, 8'h77);
    wr(ADDR_SRC, 8'h05);
    cyc(11 * BIT);
    rdc("lsr", ADDR_LSR, 8'h60);
    check("txd", PEER.got[$], 8'h55);
    check("frames", 8'(PEER.got.size()), 8'd19);
    wr(ADDR_IEN, 8'h0f);
    cyc(2);
    irqc(1'b1);
    ce = 1'b0;
    wr(ADDR_IEN, 8'h00);
    ce = 1'b1;
    rdc("ien", ADDR_IEN, 8'h0f);
    rst = 1'b1;
    cyc(2);
    rst = 1'b0;
    irqc(1'b0);
    rdc("ien", ADDR_IEN, 8'h00);
    rdc("src", ADDR_SRC, 8'h01);
  endtask
  ////////////////////////////////////////
  initial
  begin
    {cs_n, rd_n, wr_n} = 3'b111;
    addr = 3'h0;
    wdat = 8'h00;
    mevt = 1'b0;
    ce = 1'b1;
    rst = 1'b1;
    fail_count = 0;
    checks = 0;
    cyc(12);
    rst = 1'b0;
    t_reset();
    t_modem();
    t_tx();
    t_fifo_tx();
    t_trig(2'h0, 1);
    t_trig(2'h1, 4);
    t_trig(2'h2, 8);
    t_trig(2'h3, 14);
    t_false();
    t_err();
    t_misc();
    close_out();
  end
endmodule // tb_uart_holding_and_irq_enable
`default_nettype wire
